// ==== rtl/csl_defs.svh ====
// Constants for the charger safety-limit register bank.
// Assumes inclusion by csl_pkg, csl_regs and the test bench.
`ifndef CSL_DEFS_SVH
`define CSL_DEFS_SVH

// Register offsets
`define CSL_ADDR_STATUS_CONTROL  3'h0
`define CSL_ADDR_GENERAL_CONTROL 3'h1
`define CSL_ADDR_CTRL_BAT_VOLT   3'h2
`define CSL_ADDR_IDENTITY_INFO   3'h3
`define CSL_ADDR_TERM_FAST       3'h4
`define CSL_ADDR_SPECIAL_VOLT    3'h5
`define CSL_ADDR_SAFETY_LIMIT    3'h6
`define CSL_NUM_REGS             3'h7

// Status/control field positions
`define CSL_STAT_LSB             4
`define CSL_FAULT_LSB            0

// Safety limit: [7:4] max current code, [3:0] max voltage code
`define CSL_SAFE_CUR_LSB         4
`define CSL_SAFE_VOLT_LSB        0
// 950 mA max current (code 4), 4.20 V max voltage (code 0)
`define CSL_SAFE_DEFAULT         8'h40

// Reset values of the ordinary registers
`define CSL_REG_RESET            8'h00
// Writable bits of status/control and of the special-voltage register
`define CSL_STATCTL_WMASK        8'hC8
`define CSL_SPECIAL_WMASK        8'h3F

`endif

// ==== rtl/csl_pkg.sv ====
// Types for the charger safety-limit register bank.
// Assumes csl_defs.svh is on the include path.
`include "csl_defs.svh"
package csl_pkg;

  typedef enum logic [1:0] {
    CSL_ST_READY,
    CSL_ST_CHARGING,
    CSL_ST_DONE,
    CSL_ST_FAULT
  } csl_charge_state_t;

  typedef enum logic [2:0] {
    CSL_FLT_NORMAL,
    CSL_FLT_INPUT_OVP,
    CSL_FLT_SLEEP,
    CSL_FLT_WEAK_INPUT,
    CSL_FLT_BAT_OVP
  } csl_fault_t;

  typedef struct packed {
    logic [7:0] status_control;
    logic [7:0] general_control;
    logic [7:0] control_battery_voltage;
    logic [7:0] termination_fast_charge;
    logic [7:0] special_voltage_enable;
    logic [7:0] safety_limit;
    logic       unlocked;
    logic       bat_prev;
    logic       pin_prev;
    logic [7:0] rdata;
  } csl_state_t;

endpackage

// ==== rtl/csl_regs.sv ====
// Register bank of a single-cell charger with a lockable safety-limit register.
// Assumes a serial-bus front end that hands over one decoded register access
// per cycle, and comparator/status inputs synchronous to clock.
`timescale 1ns/1ps
`include "csl_defs.svh"

module csl_regs #(
  parameter bit         HAS_UNLOCK_PIN = 1'b1,   // Variant with the unlock pin
  parameter logic [7:0] IDENTITY_VALUE = 8'h5A   // Arbitrary identity value
) (
  input  wire logic                  clock,             // 10 MHz clock
  input  wire logic                  rstn,              // Synchronous reset, low
  input  wire logic                  wr_en,             // Register write strobe
  input  wire logic                  rd_en,             // Register read strobe
  input  wire logic [2:0]            addr,              // Register address
  input  wire logic [7:0]            wdata,             // Write data
  output logic      [7:0]            rdata,             // Read data, one cycle later
  input  wire logic                  bat_above_short,   // Battery-sense above threshold
  input  wire logic                  limit_unlock_pin,  // Unlock pin level
  input  wire csl_pkg::csl_charge_state_t charge_state, // Charger state
  input  wire csl_pkg::csl_fault_t   fault_code,        // Fault code
  output logic      [3:0]            max_current_code,  // Safety max current
  output logic      [3:0]            max_voltage_code,  // Safety max voltage
  output logic                       limit_unlocked,    // Safety limits writable
  output logic      [7:0]            general_control,   // Control register value
  output logic      [7:0]            control_battery_voltage, // Battery voltage reg
  output logic      [7:0]            termination_fast_charge, // Termination reg
  output logic      [7:0]            special_voltage_enable,  // Special voltage reg
  output logic      [7:0]            status_control_bits      // Writable status bits
);
  import csl_pkg::*;

  csl_state_t st;
  csl_state_t next_st;
  logic       pin_level;
  logic       unlock_evt;
  logic       other_write;

  function automatic logic [7:0] read_mux(input csl_state_t s, input logic [2:0] a,
                                          input logic [1:0] cs, input logic [2:0] fc);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `CSL_ADDR_STATUS_CONTROL:
      begin
        v = s.status_control & `CSL_STATCTL_WMASK;
        v[`CSL_STAT_LSB +: 2]  = cs;
        v[`CSL_FAULT_LSB +: 3] = fc;
      end
      `CSL_ADDR_GENERAL_CONTROL: v = s.general_control;
      `CSL_ADDR_CTRL_BAT_VOLT:   v = s.control_battery_voltage;
      `CSL_ADDR_IDENTITY_INFO:   v = IDENTITY_VALUE;
      `CSL_ADDR_TERM_FAST:       v = s.termination_fast_charge;
      `CSL_ADDR_SPECIAL_VOLT:    v = s.special_voltage_enable;
      `CSL_ADDR_SAFETY_LIMIT:    v = s.safety_limit;
      default:                   v = 8'h00;  // Unmapped address reads zero
    endcase
    return v;
  endfunction

  // Variant without the pin behaves as if the pin were tied high
  assign pin_level  = HAS_UNLOCK_PIN ? limit_unlock_pin : 1'b1;
  assign unlock_evt = (!st.bat_prev && bat_above_short && pin_level)
                    || (HAS_UNLOCK_PIN && !st.pin_prev && limit_unlock_pin
                        && bat_above_short);
  assign other_write = wr_en && (addr < `CSL_NUM_REGS) && (addr != `CSL_ADDR_SAFETY_LIMIT);

  always_comb
  begin
    next_st          = st;
    next_st.bat_prev = bat_above_short;
    next_st.pin_prev = limit_unlock_pin;
    if (rd_en)
      next_st.rdata = read_mux(st, addr, charge_state, fault_code);
    if (wr_en)
    begin
      unique case (addr)
        `CSL_ADDR_STATUS_CONTROL: next_st.status_control = wdata & `CSL_STATCTL_WMASK;
        `CSL_ADDR_GENERAL_CONTROL: next_st.general_control = wdata;
        `CSL_ADDR_CTRL_BAT_VOLT:  next_st.control_battery_voltage = wdata;
        `CSL_ADDR_TERM_FAST:      next_st.termination_fast_charge = wdata;
        `CSL_ADDR_SPECIAL_VOLT:   next_st.special_voltage_enable = wdata & `CSL_SPECIAL_WMASK;
        `CSL_ADDR_SAFETY_LIMIT:
        begin
          if (st.unlocked)
            next_st.safety_limit = wdata;
        end
        default: ;  // Identity and unmapped addresses ignore writes
      endcase
    end
    if (other_write)
      next_st.unlocked = 1'b0;
    // Unlock wins over a write in the same cycle
    if (unlock_evt)
    begin
      next_st.safety_limit = `CSL_SAFE_DEFAULT;
      next_st.unlocked     = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st                         <= '0;
      st.status_control          <= `CSL_REG_RESET;
      st.general_control         <= `CSL_REG_RESET;
      st.control_battery_voltage <= `CSL_REG_RESET;
      st.termination_fast_charge <= `CSL_REG_RESET;
      st.special_voltage_enable  <= `CSL_REG_RESET;
      st.safety_limit            <= `CSL_SAFE_DEFAULT;
      st.unlocked                <= 1'b0;
      // Treat inputs as already high so reset alone never unlocks
      st.bat_prev                <= 1'b1;
      st.pin_prev                <= 1'b1;
      st.rdata                   <= 8'h00;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata                   = st.rdata;
  assign max_current_code        = st.safety_limit[`CSL_SAFE_CUR_LSB +: 4];
  assign max_voltage_code        = st.safety_limit[`CSL_SAFE_VOLT_LSB +: 4];
  assign limit_unlocked          = st.unlocked;
  assign general_control         = st.general_control;
  assign control_battery_voltage = st.control_battery_voltage;
  assign termination_fast_charge = st.termination_fast_charge;
  assign special_voltage_enable  = st.special_voltage_enable;
  assign status_control_bits     = st.status_control;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_bat_unlock: assert property (
    (!st.bat_prev && bat_above_short && pin_level)
      |=> (limit_unlocked && st.safety_limit == `CSL_SAFE_DEFAULT))
    else $error("battery rise did not unlock limits");
  a_pin_unlock: assert property (
    (HAS_UNLOCK_PIN && !st.pin_prev && limit_unlock_pin && bat_above_short)
      |=> limit_unlocked)
    else $error("unlock pin rise did not unlock limits");
  a_other_lock: assert property (
    (other_write && !unlock_evt) |=> !limit_unlocked)
    else $error("write to other register left limits unlocked");
  a_locked_hold: assert property (
    (!limit_unlocked && !unlock_evt) |=> $stable(st.safety_limit))
    else $error("locked safety limit changed");
  a_default_value: assert property (
    unlock_evt |=> (max_current_code == 4'h4 && max_voltage_code == 4'h0))
    else $error("safety defaults wrong after unlock");
  a_state_read: assert property (
    (rd_en && addr == `CSL_ADDR_STATUS_CONTROL)
      |=> rdata[`CSL_STAT_LSB +: 2] == $past(charge_state))
    else $error("charge state read mismatch");
  a_fault_read: assert property (
    (rd_en && addr == `CSL_ADDR_STATUS_CONTROL)
      |=> rdata[`CSL_FAULT_LSB +: 3] == $past(fault_code))
    else $error("fault code read mismatch");
  a_safe_write: assert property (
    (wr_en && addr == `CSL_ADDR_SAFETY_LIMIT && limit_unlocked && !unlock_evt)
      |=> st.safety_limit == $past(wdata) ##1 1'b1)
    else $error("unlocked safety write not stored");
  a_unmapped_zero: assert property (
    (rd_en && addr == 3'h7) |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // Reset, lock and unlock
  a_reset_state: assert property (
    disable iff (1'b0) !rstn |=> (!limit_unlocked && st.safety_limit == `CSL_SAFE_DEFAULT))
    else $error("reset did not restore safety defaults");

  a_lock_holds: assert property (
    (!limit_unlocked && !unlock_evt) |=> !limit_unlocked)
    else $error("limits unlocked without an unlock event");

  a_low_bat_locked: assert property (
    (!limit_unlocked && !bat_above_short) |=> !limit_unlocked)
    else $error("limits unlocked with battery below threshold");

  a_unlock_wins: assert property (
    (unlock_evt && other_write)
      |=> (limit_unlocked && st.safety_limit == `CSL_SAFE_DEFAULT))
    else $error("write beat unlock in the same cycle");

  // Register port writes and reads
  a_rdata_hold: assert property (
    !rd_en |=> $stable(rdata))
    else $error("read data changed without a read");

  a_identity_read: assert property (
    (rd_en && addr == `CSL_ADDR_IDENTITY_INFO) |=> rdata == IDENTITY_VALUE)
    else $error("identity read mismatch");

  a_ctrl_write: assert property (
    (wr_en && addr == `CSL_ADDR_GENERAL_CONTROL) |=> general_control == $past(wdata))
    else $error("control write not stored");

  a_term_write: assert property (
    (wr_en && addr == `CSL_ADDR_TERM_FAST) |=> termination_fast_charge == $past(wdata))
    else $error("termination write not stored");

  a_special_mask: assert property (
    (wr_en && addr == `CSL_ADDR_SPECIAL_VOLT)
      |=> special_voltage_enable == ($past(wdata) & `CSL_SPECIAL_WMASK))
    else $error("special-voltage write mask wrong");

  a_status_mask: assert property (
    (wr_en && addr == `CSL_ADDR_STATUS_CONTROL)
      |=> status_control_bits == ($past(wdata) & `CSL_STATCTL_WMASK))
    else $error("status write mask wrong");

  c_unlock_write: cover property (
    unlock_evt ##1 (wr_en && addr == `CSL_ADDR_SAFETY_LIMIT));
  c_relock: cover property (limit_unlocked ##1 other_write ##1 !limit_unlocked);
  c_locked_write: cover property (
    !limit_unlocked && wr_en && addr == `CSL_ADDR_SAFETY_LIMIT && !unlock_evt);
  c_pin_unlock: cover property (
    HAS_UNLOCK_PIN && !st.pin_prev && limit_unlock_pin && bat_above_short);
  c_unlock_beats_write: cover property (unlock_evt && other_write);
endmodule // csl_regs

// ==== tb/csl_host_model.sv ====
// Host model: one decoded register access at a time on the register port.
// Assumes the bench clock; the bench calls wr and rd only after reset release.
`timescale 1ns/1ps
module csl_host_model (
  input  wire logic       clock, // Bench clock
  output logic            wr_en, // Write strobe
  output logic            rd_en, // Read strobe
  output logic [2:0]      addr,  // Register address
  output logic [7:0]      wdata, // Write data
  input  wire logic [7:0] rdata  // Read data
);
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 3'h0;
    wdata = 8'h00;
  end
  // Callers write the limits both while locked and after an unlock, and write other registers at any time
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    wdata <= ~d;
    @(negedge clock);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    addr  <= ~a;
    @(negedge clock);
    d = rdata;
  endtask
endmodule // csl_host_model

// ==== tb/charger_safety_limit_regs_test.sv ====
// Self-checking bench for the safety-limit register bank.
// Assumes csl_pkg and csl_regs are compiled first.
`timescale 1ns/1ps
`include "csl_defs.svh"
module charger_safety_limit_regs_test;
  import csl_pkg::*;
  logic              clock, rstn, wr_en, rd_en, bat, pin, unl;
  logic [2:0]        addr;
  logic [7:0]        wdata, rdata, gc, cbv, tfc, sve, scb, d, v, sc;
  logic [3:0]        cur, vol;
  logic [2:0]        tbl [3] = '{3'h1, 3'h2, 3'h4};
  csl_charge_state_t cs;
  csl_fault_t        fc;
  int                err_count, n_compared, seed;
  int                cycles = 0;
  // Arbitrary identity value, handed to the design and expected on reads
  localparam logic [7:0] ID_VALUE = 8'h5A;

  csl_host_model host (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata));
  csl_regs #(.HAS_UNLOCK_PIN(1'b1), .IDENTITY_VALUE(ID_VALUE))
    dut (.clock(clock), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .bat_above_short(bat), .limit_unlock_pin(pin),
    .charge_state(cs), .fault_code(fc), .max_current_code(cur), .max_voltage_code(vol),
    .limit_unlocked(unl), .general_control(gc), .control_battery_voltage(cbv),
    .termination_fast_charge(tfc), .special_voltage_enable(sve), .status_control_bits(scb));

  function automatic logic [7:0] exp_status(logic [7:0] c, logic [1:0] s, logic [2:0] f);
    return {c[7:6], s, c[3], f};
  endfunction

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    {rstn, bat, pin, err_count, n_compared} = '0;
    {cs, fc} = '0;
    seed = 47522;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk({cur, vol, unl} === 9'h080, "reset limits");
    host.wr(3'h6, 8'h9A);
    chk({cur, vol, unl} === 9'h080, "locked after reset");
    @(posedge clock);
    pin <= 1'b1;
    @(posedge clock);
    bat <= 1'b1;
    repeat (2) @(negedge clock);
    chk(unl === 1'b1 && {cur, vol} === 8'h40, "battery rise unlock");
    v = 8'($random(seed));
    host.wr(3'h6, v);
    chk({cur, vol} === v, "limit write");
    d = 8'($random(seed));
    host.wr(3'h1, d);
    chk(unl === 1'b0 && gc === d, "lock by other write");
    host.wr(3'h6, ~v);
    chk({cur, vol} === v, "write while locked");
    $display("test battery unlock done");
    for (int a = 0; a < 6; a++)
    begin
      @(posedge clock);
      pin <= 1'b0;
      @(posedge clock);
      pin <= 1'b1;
      repeat (2) @(negedge clock);
      chk(unl === 1'b1 && {cur, vol} === 8'h40, "pin unlock");
      d = 8'($random(seed));
      host.wr(a[2:0], d);
      chk(unl === 1'b0, "lock on write");
    end
    // Pin rise and a write to another register in one cycle: unlock wins
    @(posedge clock);
    pin <= 1'b0;
    d = 8'($random(seed));
    fork
      host.wr(3'h1, d);
      begin
        @(posedge clock);
        pin <= 1'b1;
      end
    join
    chk(unl === 1'b1 && {cur, vol} === 8'h40 && gc === d, "unlock beats write");
    $display("test pin unlock done");
    sc = 8'($random(seed));
    host.wr(3'h0, sc);
    chk(scb === (sc & `CSL_STATCTL_WMASK), "status bits");
    for (int i = 0; i < 24; i++)
    begin
      v = 8'($random(seed));
      host.wr(tbl[i % 3], v);
      chk((i % 3 == 0 ? gc : i % 3 == 1 ? cbv : tfc) === v, "register output");
      host.rd(tbl[i % 3], d);
      chk(d === v, "readback");
      @(posedge clock);
      cs <= csl_charge_state_t'(i[1:0]);
      fc <= csl_fault_t'(3'(i % 5));
      host.rd(3'h0, d);
      chk(d === exp_status(sc, i[1:0], 3'(i % 5)), "status read");
    end
    host.rd(3'h7, d);
    chk(d === 8'h00, "unmapped read");
    v = 8'($random(seed));
    host.wr(3'h5, v);
    host.rd(3'h5, d);
    chk(sve === (v & `CSL_SPECIAL_WMASK) && d === (v & `CSL_SPECIAL_WMASK), "special mask");
    host.wr(3'h3, ~ID_VALUE);
    host.rd(3'h3, d);
    chk(d === ID_VALUE, "identity read");
    $display("test register access done");
    tally_and_finish();
  end
endmodule // charger_safety_limit_regs_test
